// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {logic [7:0] a, w, e; logic err;} usp_row_t;
   localparam logic [7:0] A_CR1 = 8'h68;
   localparam logic [7:0] A_CR2 = 8'h6C;
   localparam logic [7:0] A_ST  = 8'h74;
   localparam logic [7:0] A_BUF = 8'h78;
   localparam logic [7:0] A_PO  = 8'h7C;
   logic        CLOCK, NRST, PSEL, PENABLE, PWRITE, LOW_POWER, RXD;
   logic [7:0]  PADDR, got_n;
   logic [31:0] PWDATA, PRDATA, rd_v;
   logic        PREADY, PSLVERR, TXD, TX_IRQ, RX_IRQ, rd_e;
   logic [8:0]  got;
   int          fails, n_tests, i;
   int          n_tx = 0;
   int          n_rx = 0;
   usp_row_t    rows [8] = '{
      '{8'h68, 8'h3F, 8'h3E, 1'b0},
      '{8'h6C, 8'hFF, 8'h3F, 1'b0},
      '{8'h70, 8'hFF, 8'hFF, 1'b0},
      '{8'h70, 8'h00, 8'h00, 1'b0},
      '{8'h6C, 8'h00, 8'h00, 1'b0},
      '{8'h68, 8'h00, 8'h00, 1'b0},
      '{8'h74, 8'hFF, 8'h00, 1'b0},
      '{8'h00, 8'hFF, 8'h00, 1'b1}};
   // Receive rows: byte, spoil bits {stop, parity}, status after frame.
   usp_row_t    rx_rows [3] = '{
      '{8'h3C, 8'h00, 8'h04, 1'b0},
      '{8'h5A, 8'h01, 8'h84, 1'b0},
      '{8'h81, 8'h02, 8'h44, 1'b0}};

   usp_top dut_u (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .LOW_POWER(LOW_POWER), .RXD(RXD), .TXD(TXD), .TX_IRQ(TX_IRQ),
      .RX_IRQ(RX_IRQ));
   usp_remote partner_u (.clock(CLOCK), .txd(TXD), .rxd(RXD), .got(got),
      .got_n(got_n));

   initial
   begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end

   always @(negedge CLOCK)
   begin
      if (TX_IRQ === 1'b1) n_tx++;
      if (RX_IRQ === 1'b1) n_rx++;
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task finish_test;
      if (fails == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge CLOCK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= {24'h00_0000, d};
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      k = 0;
      do
      begin
         @(posedge CLOCK);
         k++;
      end
      while (PREADY !== 1'b1 && k < 20);
      if (PREADY !== 1'b1)
      begin
         fails++;
         finish_test;
      end
      rd_v = PRDATA;
      rd_e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, {24'h00_0000, e}, rd_v);
   endtask

   initial
   begin
      NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
      PADDR = 8'h00; PWDATA = 32'h0000_0000; LOW_POWER = 1'b0;
      fails = 0; n_tests = 0;
      repeat (10) @(posedge CLOCK);
      NRST <= 1'b1;
      chk("idle line", 32'h0000_0001, {31'h0, TXD});
      rd("gate", A_PO, 8'h00);
      wr(A_CR1, 8'h18);
      wr(A_PO, 8'h01);
      rd("write while ungated", A_CR1, 8'h00);
      rd("buffer", A_BUF, 8'h00);
      rd("status", A_ST, 8'h00);
      foreach (rows[k])
      begin
         wr(rows[k].a, rows[k].w);
         apb(1'b0, rows[k].a, 8'h00);
         chk("row data", {24'h00_0000, rows[k].e}, rd_v);
         chk("row error", {31'h0, rows[k].err}, {31'h0, rd_e});
      end
      // Transmit one byte with even parity.
      wr(A_CR1, 8'h18);
      wr(A_BUF, 8'hA4);
      rd("tx full", A_ST, 8'h01);
      wr(A_CR1, 8'h98);
      rd("tx busy", A_ST, 8'h02);
      wr(A_CR1, 8'hB8);
      rd("tx lock", A_CR1, 8'h98);
      for (i = 0; i < 400 && got_n !== 8'h01; i++) @(posedge CLOCK);
      chk("tx frame", 32'h0000_01A4, {23'h0, got});
      i = 0;
      do
      begin
         rd_v = 32'h0000_0002;
         apb(1'b0, A_ST, 8'h00);
         i++;
      end
      while (rd_v !== 32'h0000_0000 && i < 30);
      chk("tx done", 32'h0000_0000, rd_v);
      chk("tx irq", 32'h0000_0001, n_tx);
      // Receive frames.
      wr(A_CR1, 8'h58);
      wr(A_CR1, 8'h50);
      rd("rx lock one", A_CR1, 8'h58);
      wr(A_CR2, 8'h01);
      rd("rx lock two", A_CR2, 8'h00);
      foreach (rx_rows[k])
      begin
         fork
            partner_u.send(rx_rows[k].a, rx_rows[k].w[0], rx_rows[k].w[1]);
            begin
               repeat (80) @(posedge CLOCK);
               rd("rx busy", A_ST, 8'h08);
            end
         join
         rd("rx status", A_ST, rx_rows[k].e);
         rd("rx data", A_BUF, rx_rows[k].a);
         rd("rx cleared", A_ST, 8'h00);
      end
      partner_u.send(8'h11, 1'b0, 1'b0);
      partner_u.send(8'h22, 1'b0, 1'b0);
      rd("overrun", A_ST, 8'h24);
      rd("kept byte", A_BUF, 8'h11);
      chk("rx irq", 32'h0000_0004, n_rx);
      // Low-power entry in mid-frame; the buffer is not relied on.
      wr(A_CR1, 8'h18);
      wr(A_CR2, 8'h06);
      wr(A_CR1, 8'hD8);
      wr(A_BUF, 8'h55);
      repeat (20) @(posedge CLOCK);
      LOW_POWER <= 1'b1;
      repeat (4) @(posedge CLOCK);
      LOW_POWER <= 1'b0;
      rd("lp status", A_ST, 8'h00);
      rd("lp ctrl one", A_CR1, 8'h18);
      rd("lp ctrl two", A_CR2, 8'h06);
      wr(A_PO, 8'h00);
      rd("gated off", A_CR1, 8'h00);
      wr(A_PO, 8'h01);
      rd("gated on", A_CR1, 8'h18);
      finish_test;
   end
endmodule
`default_nettype wire

// *** bench/usp_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
module usp_remote
(
   // Clock.
   input  wire logic       clock,
   // Serial pins as seen from the far side.
   input  wire logic       txd,
   output logic            rxd,
   // Last caught frame with parity in bit 8, and a frame count.
   output logic [8:0]      got,
   output logic [7:0]      got_n
);
   // Divisor 0 with RT select 0 gives 16 clocks a bit.
   localparam int BITLEN = 16;
   logic [8:0] sh;

   // The receiver samples on the falling edge, clear of the device's updates.
   initial
   begin
      rxd   = 1'b1;
      got   = '0;
      got_n = '0;
      forever
      begin
         @(negedge clock iff txd === 1'b0);
         repeat (BITLEN / 2) @(negedge clock);
         for (int i = 0; i < 9; i++)
         begin
            repeat (BITLEN) @(negedge clock);
            sh[i] = txd;
         end
         got   = sh;
         got_n = got_n + 8'h01;
         @(negedge clock iff txd === 1'b1);
      end
   end

   // Sends one frame with even parity, which may be spoilt on request.
   task automatic send(input logic [7:0] b, input logic bad_par,
                       input logic bad_stop);
      logic [10:0] f;
      f = {~bad_stop, (^b) ^ bad_par, b, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         @(posedge clock);
         rxd <= f[i];
         repeat (BITLEN - 1) @(posedge clock);
      end
      @(posedge clock);
      rxd <= 1'b1;
      repeat (2 * BITLEN) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// *** common/usp_pkg.sv ***
package usp_pkg;

   typedef enum logic [1:0]
   {
      TX_IDLE = 2'b01,
      TX_RUN  = 2'b10
   } usp_tx_t;

   typedef enum logic [1:0]
   {
      RX_IDLE = 2'b01,
      RX_RUN  = 2'b10
   } usp_rx_t;

   typedef struct packed
   {
      logic        gate;
      logic        txe;
      logic        rxe;
      logic        stopbt;
      logic        even;
      logic        par_add;
      logic        irdasel;
      logic        brg;
      logic [2:0]  rtsel;
      logic [1:0]  rxdnc;
      logic        stopbr;
      logic [7:0]  div;
      logic        par_err;
      logic        frm_err;
      logic        ovr_err;
      logic        rx_full;
      logic        tx_full;
      logic [7:0]  rxbuf;
      logic [7:0]  txbuf;
      usp_tx_t     tx_st;
      logic [7:0]  tx_pre;
      logic [4:0]  tx_rt;
      logic [3:0]  tx_cnt;
      logic [11:0] tx_sh;
      usp_rx_t     rx_st;
      logic [7:0]  rx_pre;
      logic [4:0]  rx_rt;
      logic [3:0]  rx_cnt;
      logic [11:0] rx_sh;
      logic        rx_s1;
      logic        rx_s2;
      logic        rx_s3;
      logic        rx_lvl;
      logic        txd;
      logic        tx_irq;
      logic        rx_irq;
      logic [7:0]  rdata;
   } usp_state_t;

endpackage

// *** common/usp_regs.svh ***
`ifndef USP_REGS_SVH
`define USP_REGS_SVH

// Register indexes; the byte address is four times the index.
`define USP_IDX_CR1    6'h1A
`define USP_IDX_CR2    6'h1B
`define USP_IDX_DIV    6'h1C
`define USP_IDX_STAT   6'h1D
`define USP_IDX_BUF    6'h1E
`define USP_IDX_POFF   6'h1F

// Field positions.
`define USP_CR1_TXE    7
`define USP_CR1_RXE    6
`define USP_CR1_STOPT  5
`define USP_CR1_EVEN   4
`define USP_CR1_PAR    3
`define USP_CR1_IRSEL  2
`define USP_CR1_BASE   1
`define USP_CR2_RTSEL  5:3
`define USP_CR2_NOISE  2:1
`define USP_CR2_STOPR  0
`define USP_POFF_GATE  0

// Reset values.
`define USP_RST_BYTE   8'h00
`define USP_RST_GATE   1'b0

// Frame timing in RT clocks and frame bits.
`define USP_RT_BASE    5'h10
`define USP_FRAME_MIN  4'h9

`endif

// *** design/usp_top.sv ***
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "usp_regs.svh"
module usp_top
(
   // Clock and reset.
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Chip low-power mode, high while stop, idle or sleep is active.
   input  wire logic        LOW_POWER,
   // Serial pins.
   input  wire logic        RXD,
   output logic             TXD,
   // Interrupt requests, one-cycle pulses.
   output logic             TX_IRQ,
   output logic             RX_IRQ
);

   usp_pkg::usp_state_t s;
   usp_pkg::usp_state_t n;
   logic [5:0]  idx;
   logic        acc;
   logic        run;
   logic        tbsy;
   logic        rbsy;
   logic        wr_cr1;
   logic        wr_cr2;
   logic        wr_buf;
   logic        rd_buf;
   logic        rd_stat;
   logic        mapped;
   logic        rx_fin;
   logic [7:0]  stat;
   logic [7:0]  rv;
   logic [3:0]  tx_last;
   logic [3:0]  rx_last;
   logic [4:0]  tx_len;
   logic [4:0]  rx_len;
   logic        par;
   logic        rx_par_bad;

   localparam usp_pkg::usp_state_t RST_VAL = '{
      tx_st:  usp_pkg::TX_IDLE,
      rx_st:  usp_pkg::RX_IDLE,
      txd:    1'b1,
      rx_s1:  1'b1,
      rx_s2:  1'b1,
      rx_s3:  1'b1,
      rx_lvl: 1'b1,
      gate:   `USP_RST_GATE,
      div:    `USP_RST_BYTE,
      rxbuf:  `USP_RST_BYTE,
      txbuf:  `USP_RST_BYTE,
      default: '0
   };

   // RT clocks per bit; frame bit 1 (start) counts as odd.
   function automatic logic [4:0] rt_len
   (
      input logic [2:0] sel,
      input logic       odd
   );
      logic [4:0] v;
      v = `USP_RT_BASE;
      case (sel)
         3'h1:    v = odd ? `USP_RT_BASE : `USP_RT_BASE + 5'h01;
         3'h2:    v = `USP_RT_BASE - 5'h01;
         3'h3:    v = odd ? `USP_RT_BASE - 5'h01 : `USP_RT_BASE;
         3'h4:    v = `USP_RT_BASE + 5'h01;
         default: v = `USP_RT_BASE;
      endcase
      return v;
   endfunction

   assign idx     = PADDR[7:2];
   assign acc     = PSEL && PENABLE;
   assign run     = s.gate && !LOW_POWER;
   assign tbsy    = s.tx_st == usp_pkg::TX_RUN;
   assign rbsy    = s.rx_st == usp_pkg::RX_RUN;
   assign wr_cr1  = acc && PWRITE && run && idx == `USP_IDX_CR1;
   assign wr_cr2  = acc && PWRITE && run && idx == `USP_IDX_CR2;
   assign wr_buf  = acc && PWRITE && run && idx == `USP_IDX_BUF;
   assign rd_buf  = acc && !PWRITE && run && idx == `USP_IDX_BUF;
   assign rd_stat = acc && !PWRITE && run && idx == `USP_IDX_STAT;
   assign mapped  = idx >= `USP_IDX_CR1 && idx <= `USP_IDX_POFF;
   // Bit 4 is hard-wired low.
   assign stat    = {s.par_err, s.frm_err, s.ovr_err, 1'b0,
                     rbsy, s.rx_full, tbsy, s.tx_full};
   assign tx_last = `USP_FRAME_MIN + {3'h0, s.par_add} + {3'h0, s.stopbt};
   assign rx_last = `USP_FRAME_MIN + {3'h0, s.par_add} + {3'h0, s.stopbr};
   assign tx_len  = rt_len(s.rtsel, !s.tx_cnt[0]);
   assign rx_len  = rt_len(s.rtsel, !s.rx_cnt[0]);
   assign par     = s.even ? ^s.txbuf : ~^s.txbuf;
   assign rx_par_bad = s.par_add &&
                    (s.rx_sh[9] != (s.even ? ^s.rx_sh[8:1] : ~^s.rx_sh[8:1]));
   assign rx_fin  = run && rbsy && s.rx_pre == s.div &&
                    s.rx_rt == (rx_len >> 1) && s.rx_cnt == rx_last &&
                    !(s.rx_cnt == 4'h0 && s.rx_lvl);

   assign PRDATA  = {24'h00_0000, s.rdata};
   assign PREADY  = 1'b1;
   assign PSLVERR = acc && !mapped;
   assign TXD     = s.txd;
   assign TX_IRQ  = s.tx_irq;
   assign RX_IRQ  = s.rx_irq;

   always_comb
   begin
      n = s;
      n.tx_irq = 1'b0;
      n.rx_irq = 1'b0;
      n.rx_s1 = RXD;
      n.rx_s2 = s.rx_s1;
      n.rx_s3 = s.rx_s2;
      if (s.rx_s2 == s.rx_s3)
      begin
         n.rx_lvl = s.rx_s3;
      end

      // Read data is staged in the setup cycle so it is valid in access.
      // A gated port reads as zero; only the gate register stays visible.
      case (idx)
         `USP_IDX_CR1:  rv = {s.txe, s.rxe, s.stopbt, s.even,
                             s.par_add, s.irdasel, s.brg, 1'b0};
         `USP_IDX_CR2:  rv = {2'b00, s.rtsel, s.rxdnc, s.stopbr};
         `USP_IDX_DIV:  rv = s.div;
         `USP_IDX_STAT: rv = stat;
         `USP_IDX_BUF:  rv = s.rxbuf;
         default:       rv = `USP_RST_BYTE;
      endcase
      if (!run)
      begin
         rv = `USP_RST_BYTE;
      end
      if (idx == `USP_IDX_POFF)
      begin
         rv = {7'h00, s.gate};
      end
      if (PSEL && !PENABLE)
      begin
         n.rdata = rv;
      end

      // Clears by software come first so that hardware sets win.
      if (rd_buf)
      begin
         n.rx_full = 1'b0;
      end
      if (rd_stat)
      begin
         n.par_err = 1'b0;
         n.frm_err = 1'b0;
         n.ovr_err = 1'b0;
      end

      // The frame state machines do not advance while the clock gate is off.
      if (run)
      begin
         case (s.tx_st)
            usp_pkg::TX_IDLE:
            begin
               if (s.txe && s.tx_full)
               begin
                  // Start, data LSB first, optional parity, stops.
                  n.tx_sh = s.par_add ? {2'b11, par, s.txbuf, 1'b0}
                                      : {3'b111, s.txbuf, 1'b0};
                  n.tx_st = usp_pkg::TX_RUN;
                  n.tx_full = 1'b0;
                  n.tx_irq = 1'b1;
                  n.tx_pre = 8'h00;
                  n.tx_rt = 5'h00;
                  n.tx_cnt = 4'h0;
               end
            end
            usp_pkg::TX_RUN:
            begin
               // A disabled transmitter finishes the frame, drops the buffer.
               if (!s.txe)
               begin
                  n.tx_full = 1'b0;
               end
               n.tx_pre = s.tx_pre + 8'h01;
               if (s.tx_pre == s.div)
               begin
                  n.tx_pre = 8'h00;
                  n.tx_rt = s.tx_rt + 5'h01;
                  if (s.tx_rt == tx_len - 5'h01)
                  begin
                     n.tx_rt = 5'h00;
                     n.tx_cnt = s.tx_cnt + 4'h1;
                     n.tx_sh = {1'b1, s.tx_sh[11:1]};
                     if (s.tx_cnt == tx_last)
                     begin
                        n.tx_st = usp_pkg::TX_IDLE;
                     end
                  end
               end
            end
            default: n.tx_st = usp_pkg::TX_IDLE;
         endcase

         case (s.rx_st)
            usp_pkg::RX_IDLE:
            begin
               if (s.rxe && !s.rx_lvl)
               begin
                  n.rx_st = usp_pkg::RX_RUN;
                  n.rx_pre = 8'h00;
                  n.rx_rt = 5'h00;
                  n.rx_cnt = 4'h0;
               end
            end
            usp_pkg::RX_RUN:
            begin
               n.rx_pre = s.rx_pre + 8'h01;
               if (s.rx_pre == s.div)
               begin
                  n.rx_pre = 8'h00;
                  n.rx_rt = s.rx_rt + 5'h01;
                  if (s.rx_rt == (rx_len >> 1))
                  begin
                     n.rx_sh[s.rx_cnt] = s.rx_lvl;
                     if (s.rx_cnt == 4'h0 && s.rx_lvl)
                     begin
                        // A start bit gone high by mid-bit was a glitch.
                        n.rx_st = usp_pkg::RX_IDLE;
                     end
                  end
                  if (rx_fin)
                  begin
                     // Only the last stop bit is checked.
                     n.rx_st = usp_pkg::RX_IDLE;
                     if (n.rx_full)
                     begin
                        n.ovr_err = 1'b1;
                     end
                     else
                     begin
                        n.rxbuf = s.rx_sh[8:1];
                        n.rx_full = 1'b1;
                        n.par_err = s.par_err || rx_par_bad;
                        n.frm_err = s.frm_err || !s.rx_lvl;
                        n.rx_irq = 1'b1;
                     end
                  end
                  else if (s.rx_rt == rx_len - 5'h01)
                  begin
                     n.rx_rt = 5'h00;
                     n.rx_cnt = s.rx_cnt + 4'h1;
                  end
               end
            end
            default: n.rx_st = usp_pkg::RX_IDLE;
         endcase
      end

      if (acc && PWRITE && idx == `USP_IDX_POFF)
      begin
         n.gate = PWDATA[`USP_POFF_GATE];
      end
      if (wr_cr1)
      begin
         n.txe = PWDATA[`USP_CR1_TXE];
         n.rxe = PWDATA[`USP_CR1_RXE];
         // Locked bits keep their value when a write is refused.
         if (!s.txe && !tbsy)
         begin
            n.stopbt = PWDATA[`USP_CR1_STOPT];
            n.irdasel = PWDATA[`USP_CR1_IRSEL];
         end
         if (!s.txe && !s.rxe && !tbsy && !rbsy)
         begin
            n.even = PWDATA[`USP_CR1_EVEN];
            n.par_add = PWDATA[`USP_CR1_PAR];
            n.brg = PWDATA[`USP_CR1_BASE];
         end
      end
      if (wr_cr2)
      begin
         if (!s.txe && !s.rxe && !tbsy && !rbsy)
         begin
            n.rtsel = PWDATA[`USP_CR2_RTSEL];
         end
         if (!s.rxe && !rbsy)
         begin
            n.rxdnc = PWDATA[`USP_CR2_NOISE];
            n.stopbr = PWDATA[`USP_CR2_STOPR];
         end
      end
      if (acc && PWRITE && run && idx == `USP_IDX_DIV)
      begin
         n.div = PWDATA[7:0];
      end
      if (wr_buf)
      begin
         n.txbuf = PWDATA[7:0];
         n.tx_full = 1'b1;
      end

      // Buffers are left as they are; software must not rely on them.
      if (LOW_POWER)
      begin
         n.txe = 1'b0;
         n.rxe = 1'b0;
         n.par_err = 1'b0;
         n.frm_err = 1'b0;
         n.ovr_err = 1'b0;
         n.rx_full = 1'b0;
         n.tx_full = 1'b0;
         n.tx_st = usp_pkg::TX_IDLE;
         n.rx_st = usp_pkg::RX_IDLE;
      end
      n.txd = (n.tx_st == usp_pkg::TX_RUN) ? n.tx_sh[0] : 1'b1;
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         s <= RST_VAL;
      end
      else
      begin
         s <= n;
      end
   end

   default clocking dc @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   a_status_bit4: assert property (
      PSEL && !PENABLE && idx == `USP_IDX_STAT |=> !PRDATA[4])
      else $error("status bit 4 read nonzero");
   a_lp_clears: assert property (
      LOW_POWER |=> stat == 8'h00 && !s.txe && !s.rxe)
      else $error("low-power entry left flags or enables set");
   a_txfull_set: assert property (
      wr_buf && !LOW_POWER |=> s.tx_full)
      else $error("buffer write did not set full flag");
   a_txfull_clear: assert property (
      TX_IRQ && !$past(wr_buf) |-> !s.tx_full)
      else $error("full flag still set after transmit request");
   a_tx_start: assert property (
      $rose(tbsy) |-> !TXD && TX_IRQ)
      else $error("transmit began without start bit and request");
   a_lock_stop: assert property (
      wr_cr1 && (s.txe || tbsy) && !LOW_POWER |=> $stable(s.stopbt))
      else $error("transmit stop length changed while locked");
   a_lock_parity: assert property (
      wr_cr1 && (s.txe || s.rxe || tbsy || rbsy)
      |=> $stable(s.par_add) && $stable(s.even) && $stable(s.brg))
      else $error("parity setting changed while locked");
   a_lock_rxstop: assert property (
      wr_cr2 && (s.rxe || rbsy) |=> $stable(s.stopbr) && $stable(s.rxdnc))
      else $error("receive setting changed while locked");
   a_gate_freeze: assert property (
      !s.gate && !LOW_POWER |=> $stable(s.tx_sh) && $stable(s.rx_sh))
      else $error("port advanced with clock gate off");
   a_rx_land: assert property (
      rx_fin && !s.rx_full && !LOW_POWER |=> s.rx_full && RX_IRQ)
      else $error("completed frame did not fill buffer");
   a_rx_ovr: assert property (
      rx_fin && s.rx_full && !rd_buf && !LOW_POWER |=> s.ovr_err && !RX_IRQ)
      else $error("frame into full buffer did not flag overrun");

endmodule
`default_nettype wire
